// ### include/ovs_pkg.sv
// Package of constants for the three-stage overvoltage block
package ovs_pkg;
  // Stage count and setting groups
  localparam int NUM_STAGES = 3;
  localparam int NUM_GROUPS = 4;
  localparam int GRP_W = 2;
  // Magnitude, threshold, hysteresis and timer widths, magnitudes in units of 0.1 percent of rated
  localparam int MAG_W = 12;
  localparam int THR_W = 8;
  localparam int HYS_W = 8;
  localparam int TIM_W = 15;
  // Threshold limits in percent of rated
  localparam logic [THR_W-1:0] THR_MIN = 8'h32;
  localparam logic [THR_W-1:0] THR_MAX_LOW = 8'h96;
  localparam logic [THR_W-1:0] THR_MAX_HIGH = 8'hA0;
  // Hysteresis limits in tenths of a percent, default three percent
  localparam logic [HYS_W-1:0] HYS_MIN = 8'h01;
  localparam logic [HYS_W-1:0] HYS_MAX = 8'hC8;
  localparam logic [HYS_W-1:0] HYS_DEF = 8'h1E;
  // Measurement limit 160 V and rated secondary knee 100 V, in volts
  localparam logic [7:0] MEAS_LIMIT_V = 8'hA0;
  localparam logic [7:0] RATED_KNEE_V = 8'h64;
  // Operate and release delays in 10 ms ticks, minima and steps
  localparam logic [TIM_W-1:0] OPD_MIN1 = 15'h0008;
  localparam logic [TIM_W-1:0] OPD_MIN2 = 15'h0006;
  localparam logic [TIM_W-1:0] OPD_MIN3 = 15'h0004;
  localparam logic [TIM_W-1:0] REL_MIN1 = 15'h0006;
  localparam logic [TIM_W-1:0] DLY_MAX = 15'h7530;
  localparam logic [TIM_W-1:0] STEP_EVEN = 15'h0002;
  // Timer tick: 10 ms at 125 MHz
  localparam int TICK_MS = 10;
  localparam int CLK_MHZ = 125;
  localparam int TICK_CYCLES = TICK_MS * 1000 * CLK_MHZ;
endpackage

// ### rtl/ovs_stage_logic.sv
// Three definite-time overvoltage stages with groups, hysteresis and a release delay on stage one
`timescale 1ns/1ps
`default_nettype none

module ovs_stage_logic #(
  parameter int TICK_CYCLES = ovs_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Fundamental line-to-line magnitudes, 0.1 percent of rated per lsb
  input wire logic [ovs_pkg::MAG_W-1:0] lineVoltageFirst,
  input wire logic [ovs_pkg::MAG_W-1:0] lineVoltageSecond,
  input wire logic [ovs_pkg::MAG_W-1:0] lineVoltageThird,
  // Rated VT secondary in volts
  input wire logic [7:0] ratedSecondaryV,
  // Setting write port: stage, group, values, one-cycle strobe
  input wire logic setWrite,
  input wire logic [1:0] setStage,
  input wire logic [ovs_pkg::GRP_W-1:0] setGroup,
  input wire logic [ovs_pkg::THR_W-1:0] setThreshold,
  input wire logic [ovs_pkg::HYS_W-1:0] setHysteresis,
  input wire logic [ovs_pkg::TIM_W-1:0] setOperateDelay,
  input wire logic [ovs_pkg::TIM_W-1:0] setReleaseDelay,
  // Active group select
  input wire logic [ovs_pkg::GRP_W-1:0] activeGroup,
  // Stage outputs and write refusal flag
  output logic [2:0] stageStart,
  output logic [2:0] stageTrip,
  output logic setReject
);

  localparam int NS = ovs_pkg::NUM_STAGES;
  localparam int NG = ovs_pkg::NUM_GROUPS;

  // Settings memory, each stage and group; release delay per group only
  logic [ovs_pkg::THR_W-1:0] thrMem_q [NS][NG];
  logic [ovs_pkg::HYS_W-1:0] hysMem_q [NS][NG];
  logic [ovs_pkg::TIM_W-1:0] opdMem_q [NS][NG];
  logic [ovs_pkg::TIM_W-1:0] relMem_q [NG];

  // Tick divider
  logic [23:0] divCnt_q;
  logic tick;
  logic [ovs_pkg::MAG_W-1:0] vMax;
  logic [ovs_pkg::TIM_W-1:0] opTimer_q [NS];
  logic [ovs_pkg::TIM_W-1:0] relTimer_q;
  logic [NS-1:0] fault;
  logic [NS-1:0] faultHeld_q;
  logic writeOk;

  // Largest of the three line-to-line magnitudes; no line-to-neutral input exists
  always_comb begin
    vMax = lineVoltageFirst;
    if (lineVoltageSecond > vMax) begin
      vMax = lineVoltageSecond;
    end
    if (lineVoltageThird > vMax) begin
      vMax = lineVoltageThird;
    end
  end

  // One tick per 10 ms, the delay resolution
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      divCnt_q <= 24'h000000;
    end else if (divCnt_q == 24'(TICK_CYCLES - 1)) begin
      divCnt_q <= 24'h000000;
    end else begin
      divCnt_q <= divCnt_q + 24'h000001;
    end
  end
  assign tick = (divCnt_q == 24'(TICK_CYCLES - 1));

  // Range check of a setting write; out-of-range writes are refused whole
  always_comb begin
    logic [ovs_pkg::THR_W-1:0] thrMax;
    logic [ovs_pkg::TIM_W-1:0] opdMin;
    logic oddStepOk;
    opdMin = ovs_pkg::OPD_MIN3;
    oddStepOk = 1'b0;
    thrMax = (setStage == 2'h2) ? ovs_pkg::THR_MAX_HIGH : ovs_pkg::THR_MAX_LOW;
    // Above 100 V secondary the 160 V measurement range caps stages two and three
    if (setStage != 2'h0 && ratedSecondaryV > ovs_pkg::RATED_KNEE_V) begin
      if (thrMax > 8'(({8'h00, ovs_pkg::MEAS_LIMIT_V} * 16'h0064) / {8'h00, ratedSecondaryV})) begin
        thrMax = 8'(({8'h00, ovs_pkg::MEAS_LIMIT_V} * 16'h0064) / {8'h00, ratedSecondaryV});
      end
    end
    unique case (setStage)
      2'h0: opdMin = ovs_pkg::OPD_MIN1;
      2'h1: opdMin = ovs_pkg::OPD_MIN2;
      default: opdMin = ovs_pkg::OPD_MIN3;
    endcase
    // Stage three steps by 10 ms, the others by 20 ms
    oddStepOk = (setStage == 2'h2) || (setOperateDelay[0] == 1'b0);
    writeOk = (setStage != 2'h3)
      && setThreshold >= ovs_pkg::THR_MIN && setThreshold <= thrMax
      && setHysteresis >= ovs_pkg::HYS_MIN && setHysteresis <= ovs_pkg::HYS_MAX
      && setOperateDelay >= opdMin && setOperateDelay <= ovs_pkg::DLY_MAX && oddStepOk
      && (setStage != 2'h0 || (setReleaseDelay >= ovs_pkg::REL_MIN1
      && setReleaseDelay <= ovs_pkg::DLY_MAX && setReleaseDelay[0] == 1'b0));
  end

  // Settings storage with documented-style defaults after reset
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      for (int s = 0; s < NS; s++) begin
        for (int g = 0; g < NG; g++) begin
          thrMem_q[s][g] <= ovs_pkg::THR_MAX_LOW;
          hysMem_q[s][g] <= ovs_pkg::HYS_DEF;
          opdMem_q[s][g] <= ovs_pkg::DLY_MAX;
        end
      end
      for (int g = 0; g < NG; g++) begin
        relMem_q[g] <= ovs_pkg::REL_MIN1;
      end
    end else if (setWrite && writeOk) begin
      thrMem_q[setStage][setGroup] <= setThreshold;
      hysMem_q[setStage][setGroup] <= setHysteresis;
      opdMem_q[setStage][setGroup] <= setOperateDelay;
      if (setStage == 2'h0) begin
        relMem_q[setGroup] <= setReleaseDelay;
      end
    end
  end

  // Refused write flag, one cycle after the strobe
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      setReject <= 1'b0;
    end else begin
      setReject <= setWrite && !writeOk;
    end
  end

  // Fault detection with hysteresis per stage
  // Compare vMax*1000 against thr*10*(1000-hys): exact in integers, no rounding drift
  always_comb begin
    logic [31:0] pick;
    logic [31:0] drop;
    pick = 32'h00000000;
    drop = 32'h00000000;
    fault = '0;
    for (int s = 0; s < NS; s++) begin
      pick = 32'(thrMem_q[s][activeGroup]) * 32'h0000000A;
      drop = pick * (32'h000003E8 - 32'(hysMem_q[s][activeGroup]));
      if (faultHeld_q[s]) begin
        fault[s] = (32'(vMax) * 32'h000003E8) >= drop;
      end else begin
        fault[s] = 32'(vMax) > pick;
      end
    end
  end

  // Held fault state per stage
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      faultHeld_q <= '0;
    end else begin
      faultHeld_q <= fault;
    end
  end

  // Start outputs follow the fault state directly
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      stageStart <= 3'h0;
    end else begin
      stageStart <= fault;
    end
  end

  // Operate timers, definite time per stage
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      for (int s = 0; s < NS; s++) begin
        opTimer_q[s] <= '0;
      end
      relTimer_q <= '0;
    end else begin
      for (int s = 0; s < NS; s++) begin
        if (fault[s]) begin
          if (tick && opTimer_q[s] != ovs_pkg::DLY_MAX) begin
            opTimer_q[s] <= opTimer_q[s] + 15'h0001;
          end
        end else if (s == 0) begin
          // Stage one keeps the elapsed time until the release delay runs out
          if (relTimer_q >= relMem_q[activeGroup]) begin
            opTimer_q[s] <= '0;
          end
        end else begin
          opTimer_q[s] <= '0;
        end
      end
      if (fault[0]) begin
        relTimer_q <= '0;
      end else if (tick && relTimer_q < relMem_q[activeGroup]) begin
        relTimer_q <= relTimer_q + 15'h0001;
      end
    end
  end

  // Trip outputs; minimum setting trips after the built-in detection span only
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      stageTrip <= 3'h0;
    end else begin
      for (int s = 0; s < NS; s++) begin
        // Minimum delay counts as instantaneous: trip at once on start
        stageTrip[s] <= fault[s] && (opTimer_q[s] >= opdMem_q[s][activeGroup]
          || opdMem_q[s][activeGroup] == (s == 0 ? ovs_pkg::OPD_MIN1
          : (s == 1 ? ovs_pkg::OPD_MIN2 : ovs_pkg::OPD_MIN3)));
      end
    end
  end

  // Start follows fault by one clock
  start_follow_a: assert property (@(posedge clk_sys) disable iff (reset)
    stageStart == $past(fault)) else $error("start does not follow fault");
  // Stage two trip never without start
  trip_needs_start_a: assert property (@(posedge clk_sys) disable iff (reset)
    stageTrip[1] |-> stageStart[1]) else $error("trip without start");
  // Stage three clears timer on drop
  timer_clear_a: assert property (@(posedge clk_sys) disable iff (reset)
    $fell(faultHeld_q[2]) |-> opTimer_q[2] == '0) else $error("timer not cleared");
  // Stage one timer held during release delay
  release_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
    (!fault[0] && relTimer_q < relMem_q[activeGroup]) |=> opTimer_q[0] == $past(opTimer_q[0]))
    else $error("timer lost in release delay");
  // A threshold below the minimum raises the refusal flag
  write_guard_a: assert property (@(posedge clk_sys) disable iff (reset)
    (setWrite && setThreshold < ovs_pkg::THR_MIN) |=> setReject) else $error("bad write accepted");
  // Inside the hysteresis band a started stage one stays started on the output
  hyst_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
    (stageStart[0] && 32'(vMax) * 32'h000003E8 >= 32'(thrMem_q[0][activeGroup]) * 32'h0000000A
    * (32'h000003E8 - 32'(hysMem_q[0][activeGroup]))) |=> stageStart[0]) else $error("hysteresis lost");
  // Stage one in steps: a drop keeps the elapsed time, an expired release clears it
  sequence stage_one_drop_s;
    faultHeld_q[0] && !fault[0];
  endsequence
  sequence stage_one_kept_s;
    opTimer_q[0] == $past(opTimer_q[0]);
  endsequence
  sequence release_over_s;
    !fault[0] && relTimer_q >= relMem_q[activeGroup];
  endsequence
  sequence stage_one_tick_s;
    fault[0] && tick && opTimer_q[0] != ovs_pkg::DLY_MAX;
  endsequence
  drop_keeps_a: assert property (@(posedge clk_sys) disable iff (reset)
    stage_one_drop_s |=> stage_one_kept_s) else $error("elapsed time lost at drop");
  release_clear_a: assert property (@(posedge clk_sys) disable iff (reset)
    release_over_s |=> opTimer_q[0] == '0) else $error("timer kept after release delay");
  // Fault returning inside the release delay counts on from the kept value
  resume_count_a: assert property (@(posedge clk_sys) disable iff (reset)
    stage_one_tick_s |=> opTimer_q[0] == $past(opTimer_q[0]) + 15'h0001)
    else $error("timer did not count on");
  // Any trip bit implies its start bit, all three stages
  trip_all_start_a: assert property (@(posedge clk_sys) disable iff (reset)
    (stageTrip & ~stageStart) == 3'h0) else $error("trip bit without start bit");
  // Stage two clears its timer on the drop as well
  timer_clear_two_a: assert property (@(posedge clk_sys) disable iff (reset)
    $fell(faultHeld_q[1]) |-> opTimer_q[1] == '0) else $error("stage two timer not cleared");
  // Minimum operate setting trips together with start
  instant_trip_a: assert property (@(posedge clk_sys) disable iff (reset)
    (fault[1] && opdMem_q[1][activeGroup] == ovs_pkg::OPD_MIN2) |=> stageTrip[1]) else $error("no instant trip");
  // A line above the stage one threshold starts it whatever the held state
  over_start_a: assert property (@(posedge clk_sys) disable iff (reset)
    (32'(vMax) > 32'(thrMem_q[0][activeGroup]) * 32'h0000000A) |=> stageStart[0]) else $error("no start");
  // Below the hysteresis band stage one releases
  below_band_a: assert property (@(posedge clk_sys) disable iff (reset)
    (32'(vMax) * 32'h000003E8 < 32'(thrMem_q[0][activeGroup]) * 32'h0000000A
    * (32'h000003E8 - 32'(hysMem_q[0][activeGroup]))) |=> !stageStart[0]) else $error("start kept below band");
  // Stage code three and hysteresis outside its span are refused
  stage_refuse_a: assert property (@(posedge clk_sys) disable iff (reset)
    (setWrite && setStage == 2'h3) |=> setReject) else $error("stage code three accepted");
  hyst_refuse_a: assert property (@(posedge clk_sys) disable iff (reset)
    (setWrite && (setHysteresis < ovs_pkg::HYS_MIN || setHysteresis > ovs_pkg::HYS_MAX))
    |=> setReject) else $error("hysteresis out of span accepted");
  // Above 100 V secondary the 160 V range caps stage two
  cap_refuse_a: assert property (@(posedge clk_sys) disable iff (reset)
    (setWrite && setStage == 2'h1 && ratedSecondaryV > ovs_pkg::RATED_KNEE_V
    && 16'(setThreshold) * 16'(ratedSecondaryV) > 16'(ovs_pkg::MEAS_LIMIT_V) * 16'h0064)
    |=> setReject) else $error("threshold above measurement range accepted");

endmodule
`default_nettype wire

// ### tb/ovs_testbench.sv
// Self-checking bench for the three-stage overvoltage block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_sys, reset, setWrite, setReject;
  logic [11:0] lineVoltageFirst, lineVoltageSecond, lineVoltageThird;
  logic [7:0] ratedSecondaryV, setThreshold, setHysteresis;
  logic [1:0] setStage, setGroup, activeGroup;
  logic [14:0] setOperateDelay, setReleaseDelay;
  logic [2:0] stageStart, stageTrip;
  int miscompares = 0;
  int samplesChecked = 0;
  int n;
  // Ten-cycle tick keeps second-long delays short
  ovs_stage_logic #(.TICK_CYCLES(10)) u_ovs_stage_logic (.clk_sys(clk_sys), .reset(reset),
    .lineVoltageFirst(lineVoltageFirst), .lineVoltageSecond(lineVoltageSecond),
    .lineVoltageThird(lineVoltageThird), .ratedSecondaryV(ratedSecondaryV), .setWrite(setWrite),
    .setStage(setStage), .setGroup(setGroup), .setThreshold(setThreshold),
    .setHysteresis(setHysteresis), .setOperateDelay(setOperateDelay),
    .setReleaseDelay(setReleaseDelay), .activeGroup(activeGroup), .stageStart(stageStart),
    .stageTrip(stageTrip), .setReject(setReject));
  // Verdict, the single exit point
  task automatic conclude();
    $display("checks %0d mismatches %0d", samplesChecked, miscompares);
    if (miscompares == 0 && samplesChecked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    samplesChecked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask
  // One setting write; the refusal pulse shows in the cycle after the taking edge
  task automatic wr(input logic [1:0] st, gr, input logic [7:0] thr, hys, input logic [14:0] opd, rel,
                    input logic rej);
    @(posedge clk_sys);
    setWrite <= 1'b1;
    setStage <= st;
    setGroup <= gr;
    setThreshold <= thr;
    setHysteresis <= hys;
    setOperateDelay <= opd;
    setReleaseDelay <= rel;
    @(posedge clk_sys);
    setWrite <= 1'b0;
    #1;
    chk(16'(setReject), 16'(rej), "write refusal");
  endtask
  task automatic volts(input logic [11:0] a, b, c);
    @(posedge clk_sys);
    lineVoltageFirst <= a;
    lineVoltageSecond <= b;
    lineVoltageThird <= c;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  // Bounded wait for a trip; running out ends the run
  task automatic wtrip(input int b, input int bound);
    n = 0;
    while (n < bound && stageTrip[b] !== 1'b1) begin
      cyc(1);
      n++;
    end
    if (stageTrip[b] !== 1'b1) begin
      miscompares++;
      $display("mismatch at %0t: trip wait ran out", $time);
      conclude();
    end
  endtask
  // Trip must stay low for k cycles
  task automatic quiet(input int b, input int k);
    int bad;
    bad = 0;
    repeat (k) begin
      cyc(1);
      if (stageTrip[b] !== 1'b0) bad++;
    end
    chk(16'(bad), 16'h0000, "early trip");
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    reset = 1'b1;
    setWrite = 1'b0;
    {setStage, setGroup, activeGroup, setThreshold, setHysteresis} = '0;
    {setOperateDelay, setReleaseDelay} = '0;
    {lineVoltageFirst, lineVoltageSecond, lineVoltageThird} = '0;
    ratedSecondaryV = 8'h64;
    cyc(3);
    chk(16'({stageStart, stageTrip, setReject}), 16'h0000, "reset outputs");
    @(posedge clk_sys);
    reset <= 1'b0;
    // Setting ranges, every field past its lower limit and all but the release delay past its upper;
    // the stage three threshold maximum, the stage two hysteresis maximum and the stage two and three operate minima also at them
    wr(2'h0, 2'h0, 8'h31, 8'h1E, 15'h0014, 15'h0006, 1'b1);
    wr(2'h0, 2'h0, 8'h97, 8'h1E, 15'h0014, 15'h0006, 1'b1);
    wr(2'h2, 2'h0, 8'hA1, 8'h1E, 15'h0004, 15'h0006, 1'b1);
    wr(2'h2, 2'h0, 8'hA0, 8'h1E, 15'h0004, 15'h0006, 1'b0);
    wr(2'h1, 2'h0, 8'h64, 8'h00, 15'h0006, 15'h0006, 1'b1);
    wr(2'h1, 2'h0, 8'h64, 8'hC9, 15'h0006, 15'h0006, 1'b1);
    wr(2'h1, 2'h0, 8'h64, 8'hC8, 15'h0006, 15'h0006, 1'b0);
    wr(2'h0, 2'h0, 8'h64, 8'h1E, 15'h0007, 15'h0006, 1'b1);
    wr(2'h0, 2'h0, 8'h64, 8'h1E, 15'h0009, 15'h0006, 1'b1);
    wr(2'h1, 2'h0, 8'h64, 8'h1E, 15'h0005, 15'h0006, 1'b1);
    wr(2'h2, 2'h0, 8'h64, 8'h1E, 15'h0003, 15'h0006, 1'b1);
    wr(2'h2, 2'h0, 8'h64, 8'h1E, 15'h7531, 15'h0006, 1'b1);
    wr(2'h0, 2'h0, 8'h64, 8'h1E, 15'h0014, 15'h0005, 1'b1);
    wr(2'h0, 2'h0, 8'h64, 8'h1E, 15'h0014, 15'h0007, 1'b1);
    wr(2'h3, 2'h0, 8'h64, 8'h1E, 15'h0014, 15'h0006, 1'b1);
    @(posedge clk_sys);
    ratedSecondaryV <= 8'h6E;
    wr(2'h1, 2'h0, 8'h92, 8'h1E, 15'h0006, 15'h0006, 1'b1);
    wr(2'h1, 2'h0, 8'h91, 8'h1E, 15'h0006, 15'h0006, 1'b0);
    @(posedge clk_sys);
    ratedSecondaryV <= 8'h64;
    $display("test settings done");
    // Threshold edge, instantaneous trip, hysteresis band
    wr(2'h1, 2'h0, 8'h64, 8'h1E, 15'h0006, 15'h0006, 1'b0);
    volts(12'h000, 12'h000, 12'h3E8);
    cyc(2);
    chk(16'(stageStart), 16'h0000, "no start at threshold");
    volts(12'h000, 12'h000, 12'h3E9);
    cyc(1);
    chk(16'({stageStart, stageTrip}), 16'h0012, "start with trip");
    volts(12'h000, 12'h3CB, 12'h000);
    cyc(2);
    chk(16'(stageStart), 16'h0002, "held in band");
    volts(12'h000, 12'h000, 12'h3C9);
    cyc(1);
    chk(16'({stageStart, stageTrip}), 16'h0000, "released below band");
    $display("test start done");
    // Third stage: short fault clears timer, full fault trips on time
    wr(2'h2, 2'h0, 8'h78, 8'h1E, 15'h0009, 15'h0006, 1'b0);
    volts(12'h4B1, 12'h000, 12'h000);
    cyc(40);
    chk(16'({stageStart[2], stageTrip[2]}), 16'h0002, "started, no trip");
    volts(12'h000, 12'h000, 12'h000);
    cyc(1);
    chk(16'({stageStart[2], stageTrip[2]}), 16'h0000, "clean release");
    volts(12'h4B1, 12'h000, 12'h000);
    wtrip(2, 150);
    chk(16'(n >= 75 && n <= 105), 16'h0001, "operate delay");
    volts(12'h000, 12'h000, 12'h000);
    $display("test timer done");
    // First stage: dropout shorter than release keeps elapsed time
    wr(2'h0, 2'h0, 8'h6E, 8'h1E, 15'h0014, 15'h001E, 1'b0);
    volts(12'h44D, 12'h000, 12'h000);
    quiet(0, 120);
    volts(12'h000, 12'h000, 12'h000);
    quiet(0, 100);
    volts(12'h44D, 12'h000, 12'h000);
    wtrip(0, 140);
    chk(16'(n >= 50), 16'h0001, "resumed timer");
    volts(12'h000, 12'h000, 12'h000);
    cyc(340);
    volts(12'h44D, 12'h000, 12'h000);
    quiet(0, 150);
    volts(12'h000, 12'h000, 12'h000);
    $display("test release done");
    // Setting groups
    wr(2'h1, 2'h2, 8'h3C, 8'h1E, 15'h0006, 15'h0006, 1'b0);
    @(posedge clk_sys);
    activeGroup <= 2'h2;
    volts(12'h000, 12'h259, 12'h000);
    cyc(1);
    chk(16'(stageStart[1]), 16'h0001, "group two start");
    @(posedge clk_sys);
    activeGroup <= 2'h0;
    cyc(2);
    chk(16'(stageStart[1]), 16'h0000, "group zero quiet");
    $display("test groups done");
    conclude();
  end
endmodule
`default_nettype wire
